/* File: udcl_consts.vh */
// Constants for the USB descriptor configuration loader
`ifndef UDCL_CONSTS_VH
`define UDCL_CONSTS_VH
`define UDCL_SLAVE_WR 8'ha0
`define UDCL_SLAVE_RD 8'ha1
`define UDCL_NBYTES 4'h8
`define UDCL_SIG_ADDR 3'h7
`define UDCL_SIGNATURE 8'h5a // Arbitrary value
`define UDCL_ATTR_DEFAULT 8'ha0
`define UDCL_ATTR_FIXED 8'h80
`define UDCL_ATTR_SELF_BIT 6
`define UDCL_ATTR_WAKE_BIT 5
`define UDCL_MAXPWR_MA 94
`define UDCL_MAXPWR_DEFAULT 8'h2f
`define UDCL_MPS_NORMAL 8'h40
`define UDCL_MPS_CDC 8'h3f
`define UDCL_FLOW_CDC 8'h01
`define UDCL_FLOW_NONE 8'h00
`define UDCL_PINMODE_CDC 8'h01
`define UDCL_PINMODE_NONE 8'h00
`define UDCL_INTMASK_CDC 8'h30
`define UDCL_INTMASK_NONE 8'h00
`define UDCL_DIR_CDC 8'h08
`define UDCL_DIR_NONE 8'h00
`define UDCL_BAUD_DEFAULT 24'd9600
`define UDCL_DATA_BITS 4'h8
`define UDCL_STOP_BITS 2'h1
`define UDCL_NUM_CONFIGS 8'h01
`define UDCL_NUM_IFACES 8'h02
`define UDCL_NUM_EPS 8'h03
`define UDCL_CLK_MHZ 125
`define UDCL_SCL_KHZ 400 // Fast mode keeps the power-up probe short
`define UDCL_QTR_CYC (`UDCL_CLK_MHZ * 1000 / (`UDCL_SCL_KHZ * 4))
`endif

/* File: udcl_i2c_byte.v */
// Two-wire bus bit engine: start, stop, byte write and byte read
`timescale 1ns/1ps
`include "udcl_consts.vh"
module udcl_i2c_byte (
  input wire core_clk,
  input wire nrst,
  input wire cmd_start,
  input wire cmd_write,
  input wire cmd_read,
  input wire cmd_stop,
  input wire read_last,
  input wire [7:0] wr_data,
  input wire sda_in,
  output reg [7:0] rd_data,
  output reg ack_ok,
  output reg done,
  output reg scl_oe,
  output reg sda_oe
);
  localparam QTR = `UDCL_QTR_CYC;
  localparam ST_IDLE = 4'h1;
  localparam ST_START = 4'h2;
  localparam ST_BITS = 4'h4;
  localparam ST_STOP = 4'h8;
  reg [3:0] state;
  reg [9:0] tick;
  reg [1:0] phase;
  reg [3:0] bit_idx;
  reg [8:0] shreg;
  reg is_read;
  wire qtr_end;

  assign qtr_end = (tick == QTR[9:0] - 10'h001);

  // One bit takes four quarter periods; clock is low in the first two and high in the last two
  // Open-drain: enables drive low only, pull-ups give the high level
  always @(posedge core_clk)
  begin
    if (!nrst)
    begin
      state <= ST_IDLE;
      tick <= 10'h000;
      phase <= 2'h0;
      bit_idx <= 4'h0;
      shreg <= 9'h000;
      is_read <= 1'b0;
      rd_data <= 8'h00;
      ack_ok <= 1'b0;
      done <= 1'b0;
      scl_oe <= 1'b0;
      sda_oe <= 1'b0;
    end
    else
    begin
      done <= 1'b0;
      tick <= qtr_end ? 10'h000 : tick + 10'h001;
      case (state)
        ST_IDLE:
        begin
          tick <= 10'h000;
          phase <= 2'h0;
          bit_idx <= 4'h0;
          if (cmd_start)
            state <= ST_START;
          else if (cmd_write || cmd_read)
          begin
            state <= ST_BITS;
            is_read <= cmd_read;
            // Read shifts in 8 bits then drives our own ack or nack
            shreg <= cmd_read ? {8'hff, read_last} : {wr_data, 1'b1};
          end
          else if (cmd_stop)
            state <= ST_STOP;
        end
        ST_START:
          if (qtr_end)
          begin
            phase <= phase + 2'h1;
            case (phase)
              2'h0: sda_oe <= 1'b0;
              2'h1: scl_oe <= 1'b0;
              2'h2: sda_oe <= 1'b1;
              default:
              begin
                scl_oe <= 1'b1;
                state <= ST_IDLE;
                done <= 1'b1;
              end
            endcase
          end
        ST_BITS:
          if (qtr_end)
          begin
            phase <= phase + 2'h1;
            case (phase)
              2'h0: sda_oe <= ~shreg[8];
              2'h1: scl_oe <= 1'b0;
              2'h2:
                if (bit_idx == 4'h8)
                  ack_ok <= is_read ? 1'b1 : ~sda_in;
                else if (is_read)
                  rd_data <= {rd_data[6:0], sda_in};
              default:
              begin
                scl_oe <= 1'b1;
                shreg <= {shreg[7:0], 1'b1};
                bit_idx <= bit_idx + 4'h1;
                if (bit_idx == 4'h8)
                begin
                  // Data stays put while the clock falls; the next command
                  // moves it a quarter later, so no false stop is seen
                  state <= ST_IDLE;
                  done <= 1'b1;
                end
              end
            endcase
          end
        ST_STOP:
          if (qtr_end)
          begin
            phase <= phase + 2'h1;
            case (phase)
              2'h0: sda_oe <= 1'b1;
              2'h1: scl_oe <= 1'b0;
              2'h2: sda_oe <= 1'b0;
              default:
              begin
                state <= ST_IDLE;
                done <= 1'b1;
              end
            endcase
          end
        default: state <= ST_IDLE;
      endcase
    end
  end
endmodule

/* File: udcl_loader.v */
// Power-up descriptor loader: strap capture, memory probe, descriptor values
`timescale 1ns/1ps
`include "udcl_consts.vh"
module udcl_loader #(
  parameter [15:0] DEFAULT_VID = 16'h1234, // Arbitrary value
  parameter [15:0] DEFAULT_PID = 16'h5678 // Arbitrary value
) (
  input wire core_clk,
  input wire nrst,
  input wire cdc_mode,
  input wire sda_in,
  input wire scl_in,
  output wire sda_out,
  output wire sda_oe,
  output wire scl_out,
  output wire scl_oe,
  output reg load_done,
  output reg image_valid,
  output reg [15:0] id_vendor,
  output reg [15:0] id_product,
  output reg [7:0] bm_attributes,
  output reg [7:0] b_max_power,
  output reg [7:0] max_packet_size,
  output reg [7:0] num_configs,
  output reg [7:0] num_interfaces,
  output reg [7:0] num_endpoints,
  output reg [7:0] flow_control,
  output reg [7:0] pin_mode,
  output reg [7:0] pin_int_mask,
  output reg [7:0] pin_direction,
  output reg [23:0] baud_rate,
  output reg [3:0] data_bits,
  output reg parity_en,
  output reg [1:0] stop_bits
);
  localparam S_WAIT = 10'h001;
  localparam S_STRAP = 10'h002;
  localparam S_START = 10'h004;
  localparam S_ADDRW = 10'h008;
  localparam S_WORD = 10'h010;
  localparam S_RSTART = 10'h020;
  localparam S_ADDRR = 10'h040;
  localparam S_READ = 10'h080;
  localparam S_STOP = 10'h100;
  localparam S_DONE = 10'h200;
  reg [9:0] state;
  reg [9:0] next_state;
  reg sda_m;
  reg sda_s;
  reg scl_m;
  reg scl_s;
  reg [1:0] settle;
  reg strap_sda;
  reg strap_scl;
  reg [63:0] image;
  reg [3:0] count;
  reg nack_seen;
  reg issued;
  reg cmd_start;
  reg cmd_write;
  reg cmd_read;
  reg cmd_stop;
  reg [7:0] wr_data;
  wire [7:0] rd_data;
  wire ack_ok;
  wire done;
  wire sig_ok;
  wire [7:0] strap_attr;

  // Pins come from outside the clock domain; two flops before use
  always @(posedge core_clk)
  begin
    if (!nrst)
    begin
      sda_m <= 1'b1;
      sda_s <= 1'b1;
      scl_m <= 1'b1;
      scl_s <= 1'b1;
    end
    else
    begin
      sda_m <= sda_in;
      sda_s <= sda_m;
      scl_m <= scl_in;
      scl_s <= scl_m;
    end
  end

  // Open-drain outputs never drive high
  assign sda_out = 1'b0;
  assign scl_out = 1'b0;

  udcl_i2c_byte u_byte (
    .core_clk(core_clk),
    .nrst(nrst),
    .cmd_start(cmd_start),
    .cmd_write(cmd_write),
    .cmd_read(cmd_read),
    .cmd_stop(cmd_stop),
    .read_last(count == 4'h7),
    .wr_data(wr_data),
    .sda_in(sda_s),
    .rd_data(rd_data),
    .ack_ok(ack_ok),
    .done(done),
    .scl_oe(scl_oe),
    .sda_oe(sda_oe)
  );

  // Image is good only with every ack seen and the signature in byte 7
  assign sig_ok = !nack_seen &&
    (image[8*`UDCL_SIG_ADDR +: 8] == `UDCL_SIGNATURE);
  // Strap decode: data low means wakeup, clock high means self-powered
  assign strap_attr = `UDCL_ATTR_FIXED |
    ({7'h00, strap_scl} << `UDCL_ATTR_SELF_BIT) |
    ({7'h00, ~strap_sda} << `UDCL_ATTR_WAKE_BIT);

  // Sequencer next state
  always @*
  begin
    next_state = state;
    case (state)
      S_WAIT: if (settle == 2'h3) next_state = S_STRAP;
      S_STRAP: next_state = (strap_sda && strap_scl) ? S_START : S_DONE;
      S_START: if (done) next_state = S_ADDRW;
      S_ADDRW: if (done) next_state = ack_ok ? S_WORD : S_STOP;
      S_WORD: if (done) next_state = ack_ok ? S_RSTART : S_STOP;
      S_RSTART: if (done) next_state = S_ADDRR;
      S_ADDRR: if (done) next_state = ack_ok ? S_READ : S_STOP;
      S_READ: if (done && count == 4'h7) next_state = S_STOP;
      S_STOP: if (done) next_state = S_DONE;
      S_DONE: next_state = S_DONE;
      default: next_state = S_WAIT;
    endcase
  end

  // Byte engine commands, issued once per state entry and again after each byte in S_READ
  always @*
  begin
    cmd_start = 1'b0;
    cmd_write = 1'b0;
    cmd_read = 1'b0;
    cmd_stop = 1'b0;
    wr_data = 8'h00;
    if (!issued)
    begin
      case (state)
        S_START: cmd_start = 1'b1;
        S_RSTART: cmd_start = 1'b1;
        S_ADDRW:
        begin
          cmd_write = 1'b1;
          wr_data = `UDCL_SLAVE_WR;
        end
        S_WORD: cmd_write = 1'b1;
        S_ADDRR:
        begin
          cmd_write = 1'b1;
          wr_data = `UDCL_SLAVE_RD;
        end
        S_READ: cmd_read = 1'b1;
        S_STOP: cmd_stop = 1'b1;
        default: cmd_write = 1'b0;
      endcase
    end
  end

  // Sequencer state, strap capture and image read
  always @(posedge core_clk)
  begin
    if (!nrst)
    begin
      state <= S_WAIT;
      settle <= 2'h0;
      strap_sda <= 1'b1;
      strap_scl <= 1'b1;
      image <= 64'h0;
      count <= 4'h0;
      nack_seen <= 1'b0;
      issued <= 1'b0;
    end
    else
    begin
      state <= next_state;
      if (state == S_WAIT)
        settle <= settle + 2'h1;
      // Caught once after reset, before any bus activity
      if (state == S_WAIT && settle == 2'h3)
      begin
        strap_sda <= sda_s;
        strap_scl <= scl_s;
      end
      if (next_state != state || done)
        issued <= 1'b0;
      else if (cmd_start || cmd_write || cmd_read || cmd_stop)
        issued <= 1'b1;
      if (done && !ack_ok &&
          (state == S_ADDRW || state == S_WORD || state == S_ADDRR))
        nack_seen <= 1'b1;
      if (state == S_READ && done)
      begin
        image[8*count[2:0] +: 8] <= rd_data;
        count <= count + 4'h1;
      end
    end
  end

  // Descriptor and serial values; loaded ones settle once loading finishes, mode presets follow cdc_mode
  always @(posedge core_clk)
  begin
    if (!nrst)
    begin
      load_done <= 1'b0;
      image_valid <= 1'b0;
      id_vendor <= DEFAULT_VID;
      id_product <= DEFAULT_PID;
      bm_attributes <= `UDCL_ATTR_DEFAULT;
      b_max_power <= `UDCL_MAXPWR_DEFAULT;
      max_packet_size <= `UDCL_MPS_NORMAL;
      num_configs <= `UDCL_NUM_CONFIGS;
      num_interfaces <= `UDCL_NUM_IFACES;
      num_endpoints <= `UDCL_NUM_EPS;
      flow_control <= `UDCL_FLOW_NONE;
      pin_mode <= `UDCL_PINMODE_NONE;
      pin_int_mask <= `UDCL_INTMASK_NONE;
      pin_direction <= `UDCL_DIR_NONE;
      baud_rate <= `UDCL_BAUD_DEFAULT;
      data_bits <= `UDCL_DATA_BITS;
      parity_en <= 1'b0;
      stop_bits <= `UDCL_STOP_BITS;
    end
    else
    begin
      // Fixed configuration shape and serial defaults
      num_configs <= `UDCL_NUM_CONFIGS;
      num_interfaces <= `UDCL_NUM_IFACES;
      num_endpoints <= `UDCL_NUM_EPS;
      baud_rate <= `UDCL_BAUD_DEFAULT;
      data_bits <= `UDCL_DATA_BITS;
      parity_en <= 1'b0;
      stop_bits <= `UDCL_STOP_BITS;
      // Class driver cannot touch registers, so presets come from the mode
      max_packet_size <= cdc_mode ? `UDCL_MPS_CDC : `UDCL_MPS_NORMAL;
      flow_control <= cdc_mode ? `UDCL_FLOW_CDC : `UDCL_FLOW_NONE;
      pin_mode <= cdc_mode ? `UDCL_PINMODE_CDC : `UDCL_PINMODE_NONE;
      pin_int_mask <= cdc_mode ? `UDCL_INTMASK_CDC : `UDCL_INTMASK_NONE;
      pin_direction <= cdc_mode ? `UDCL_DIR_CDC : `UDCL_DIR_NONE;
      if (state == S_DONE && !load_done)
      begin
        load_done <= 1'b1;
        image_valid <= sig_ok;
        if (sig_ok)
        begin
          id_vendor <= image[15:0];
          id_product <= image[31:16];
          bm_attributes <= image[39:32];
          b_max_power <= image[47:40];
        end
        else
        begin
          id_vendor <= DEFAULT_VID;
          id_product <= DEFAULT_PID;
          bm_attributes <= strap_attr;
          b_max_power <= `UDCL_MAXPWR_DEFAULT;
        end
      end
    end
  end
endmodule

/* File: udcl_loader_sva.sv */
// Concurrent checks on the descriptor loader ports
`timescale 1ns/1ps
module udcl_loader_sva #(
  parameter [15:0] DEFAULT_VID = 16'h1234,
  parameter [15:0] DEFAULT_PID = 16'h5678
) (
  input wire core_clk,
  input wire nrst,
  input wire cdc_mode,
  input wire sda_in,
  input wire scl_in,
  input wire sda_oe,
  input wire scl_oe,
  input wire load_done,
  input wire image_valid,
  input wire [15:0] id_vendor,
  input wire [15:0] id_product,
  input wire [7:0] bm_attributes,
  input wire [7:0] b_max_power,
  input wire [7:0] max_packet_size,
  input wire [7:0] num_configs,
  input wire [7:0] num_interfaces,
  input wire [7:0] num_endpoints,
  input wire [7:0] flow_control,
  input wire [7:0] pin_mode,
  input wire [7:0] pin_int_mask,
  input wire [7:0] pin_direction,
  input wire [23:0] baud_rate,
  input wire [3:0] data_bits,
  input wire parity_en,
  input wire [1:0] stop_bits
);
  reg prev_nrst;
  reg cap_sda;
  reg cap_scl;
  // Pin levels as reset lifts; the bench keeps straps steady around release
  always @(posedge core_clk)
  begin
    prev_nrst <= nrst;
    if (nrst && !prev_nrst)
    begin
      cap_sda <= sda_in;
      cap_scl <= scl_in;
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);
  sequence s_rel_strap;
    $rose(nrst) ##0 !(sda_in && scl_in);
  endsequence
  sequence s_rel_probe;
    $rose(nrst) ##0 (sda_in && scl_in);
  endsequence
  sequence s_fallback;
    load_done && !image_valid;
  endsequence
  a_quick_done: assert property (s_rel_strap |-> ##[1:12] load_done)
    else $error("loader slow to settle on straps");
  a_bus_quiet: assert property (s_rel_strap |-> (!sda_oe && !scl_oe)[*8])
    else $error("bus driven without both straps high");
  a_probe_start: assert property (s_rel_probe |-> ##[1:1000] sda_oe)
    else $error("no memory probe with straps high");
  a_done_holds: assert property (load_done |=> load_done)
    else $error("load_done dropped");
  a_result_hold: assert property (load_done && $past(load_done) |->
    $stable({id_vendor, id_product, bm_attributes, b_max_power}))
    else $error("descriptor values changed after load");
  a_strap_attr: assert property (s_fallback |->
    bm_attributes == {1'b1, cap_scl, !cap_sda, 5'h00})
    else $error("attributes do not follow straps");
  a_dflt_ids: assert property (s_fallback |->
    b_max_power == 8'h2f &&
    id_vendor == DEFAULT_VID && id_product == DEFAULT_PID)
    else $error("defaults missing without valid image");
  a_mps_mode: assert property ($past(nrst) |->
    max_packet_size == ($past(cdc_mode) ? 8'h3f : 8'h40))
    else $error("max packet size wrong for driver mode");
  a_cdc_presets: assert property ($past(nrst) |->
    $past(cdc_mode) ==
    ({flow_control, pin_mode, pin_int_mask, pin_direction} == 32'h01013008))
    else $error("class driver presets wrong");
  a_usb_shape: assert property ($past(nrst) |->
    {num_configs, num_interfaces, num_endpoints} == 24'h010203)
    else $error("configuration shape wrong");
  a_serial_dflt: assert property ($past(nrst) |->
    baud_rate == 24'd9600 &&
    data_bits == 4'h8 && !parity_en && stop_bits == 2'h1)
    else $error("serial defaults wrong");
endmodule

/* File: udcl_eeprom_model.sv */
// Behavioural two-wire memory holding a descriptor image
`timescale 1ns/1ps
module udcl_eeprom_model (
  input wire scl,
  input wire sda,
  input wire nack_addr,
  input wire [7:0] sig,
  output reg sda_oe
);
  // Image bytes 6 down to 0: reserved, power, attr, pid hi/lo, vid hi/lo
  localparam [55:0] IMG = 56'h00_32_e0_ca_fe_be_ef;
  reg act, rd, got, ok;
  reg [3:0] n;
  reg [2:0] ptr;
  reg [7:0] sh, out;
  initial
  begin
    act = 1'b0;
    sda_oe = 1'b0;
    ptr = 3'h0;
  end
  // Start or repeated start resets the frame, keeping the address pointer
  always @(negedge sda)
    if (scl === 1'b1)
    begin
      {act, rd, got, ok, n, sda_oe} = {4'b1001, 4'h0, 1'b0};
    end
  // Stop ends everything; line returns to the pull-up
  always @(posedge sda)
    if (scl === 1'b1)
      {act, sda_oe} = 2'b00;
  // Bits are taken while the clock is high; a master NACK ends a read
  always @(posedge scl)
    if (act)
    begin
      if (n < 4'h8)
        sh = {sh[6:0], sda};
      else if (rd && sda)
        act = 1'b0;
      n = n + 4'h1;
    end
  // Data changes only while the clock is low, so no false start or stop
  always @(negedge scl)
    if (act)
    begin
      if (n == 4'h8 && !rd)
      begin
        if (!got)
        begin
          ok = (sh[7:1] == 7'h50) && !nack_addr;
          rd = sh[0];
          got = 1'b1;
        end
        else
          ptr = sh[2:0];
        sda_oe = ok;
        act = ok;
      end
      else if (n == 4'h8)
      begin
        sda_oe = 1'b0;
        ptr = ptr + 3'h1;
      end
      else
      begin
        if (n == 4'h9)
        begin
          n = 4'h0;
          out = (ptr == 3'h7) ? sig : IMG[ptr * 8 +: 8];
        end
        sda_oe = rd && !out[4'h7 - n];
      end
    end
endmodule

/* File: udcl_loader_bench.sv */
// Self-checking bench: strap decoding, memory probe and driver presets
`timescale 1ns/1ps
module udcl_loader_bench;
  reg core_clk, nrst, cdc_mode, sda_pd, scl_pd, nack_addr;
  reg [7:0] sig;
  wire sda_out, sda_oe, scl_out, scl_oe, load_done, image_valid, mem_oe;
  wire parity_en;
  wire [15:0] id_vendor, id_product;
  wire [7:0] bm_attributes, b_max_power, max_packet_size, num_configs;
  wire [7:0] num_interfaces, num_endpoints, flow_control, pin_mode;
  wire [7:0] pin_int_mask, pin_direction;
  wire [23:0] baud_rate;
  wire [3:0] data_bits;
  wire [1:0] stop_bits;
  integer fail_count, num_checks, k;
  // Open-drain wires with pull-ups; a strap pull-down wins when fitted
  wire sda_w = (sda_oe && !sda_out) || mem_oe || sda_pd ? 1'b0 : 1'b1;
  wire scl_w = (scl_oe && !scl_out) || scl_pd ? 1'b0 : 1'b1;
  udcl_loader udcl_loader_inst (.core_clk(core_clk), .nrst(nrst),
    .cdc_mode(cdc_mode), .sda_in(sda_w), .scl_in(scl_w),
    .sda_out(sda_out), .sda_oe(sda_oe), .scl_out(scl_out), .scl_oe(scl_oe),
    .load_done(load_done), .image_valid(image_valid),
    .id_vendor(id_vendor), .id_product(id_product),
    .bm_attributes(bm_attributes), .b_max_power(b_max_power),
    .max_packet_size(max_packet_size), .num_configs(num_configs),
    .num_interfaces(num_interfaces), .num_endpoints(num_endpoints),
    .flow_control(flow_control), .pin_mode(pin_mode),
    .pin_int_mask(pin_int_mask), .pin_direction(pin_direction),
    .baud_rate(baud_rate), .data_bits(data_bits), .parity_en(parity_en),
    .stop_bits(stop_bits));
  udcl_eeprom_model udcl_eeprom_model_inst (.scl(scl_w), .sda(sda_w),
    .nack_addr(nack_addr), .sig(sig), .sda_oe(mem_oe));
  // 125 MHz core clock
  initial
  begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  task chk(input [23:0] got, input [23:0] exp);
  begin
    num_checks = num_checks + 1;
    if (got !== exp)
    begin
      fail_count = fail_count + 1;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  end
  endtask
  task report_and_stop;
  begin
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  end
  endtask
  // Reset with the pins set up first, then wait for the loader to settle
  task run(input s_pd, input c_pd, input nk, input [7:0] sg);
    integer i;
  begin
    @(negedge core_clk);
    {nrst, sda_pd, scl_pd, nack_addr, sig} = {1'b0, s_pd, c_pd, nk, sg};
    repeat (6) @(negedge core_clk);
    nrst = 1'b1;
    i = 0;
    while (load_done !== 1'b1 && i < 40000)
    begin
      @(negedge core_clk);
      i = i + 1;
    end
    if (i >= 40000)
    begin
      fail_count = fail_count + 1;
      $display("BAD %0t load never finished", $time);
      report_and_stop;
    end
  end
  endtask
  task chk_fallback(input s, input c);
  begin
    chk(image_valid, 1'b0);
    chk(id_vendor, 16'h1234);
    chk(id_product, 16'h5678);
    chk(bm_attributes, {1'b1, c, !s, 5'h00});
    chk(b_max_power, 8'h2f);
  end
  endtask
  task chk_mode;
    integer m;
  begin
    for (m = 0; m < 2; m = m + 1)
    begin
      cdc_mode = m[0];
      repeat (2) @(negedge core_clk);
      chk(max_packet_size, m ? 8'h3f : 8'h40);
      chk({flow_control, pin_mode}, m ? 16'h0101 : 16'h0000);
      chk({pin_int_mask, pin_direction}, m ? 16'h3008 : 16'h0);
    end
    chk({num_configs, num_interfaces, num_endpoints}, 24'h010203);
    chk(baud_rate, 24'd9600);
    chk({data_bits, parity_en, stop_bits}, 24'h000041);
  end
  endtask
  // Strap cases, late pin changes, then valid, bad and refused images
  initial
  begin
    {nrst, cdc_mode, sda_pd, scl_pd, nack_addr, sig} = 13'h0;
    fail_count = 0;
    num_checks = 0;
    for (k = 0; k < 3; k = k + 1)
    begin
      run(k != 1, k != 2, 1'b0, 8'h5a);
      chk_fallback(k == 1, k == 2);
      {sda_pd, scl_pd} = 2'b00;
      repeat (3000) @(negedge core_clk);
      chk({sda_oe, bm_attributes}, {1'b0, 1'b1, k == 2, k != 1, 5'h0});
      $display("strap test %0d done", k);
    end
    chk_mode;
    $display("driver mode test done");
    run(1'b0, 1'b0, 1'b0, 8'h5a);
    chk(image_valid, 1'b1);
    chk(id_vendor, 16'hbeef);
    chk(id_product, 16'hcafe);
    chk(bm_attributes, 8'he0);
    chk(b_max_power, 8'h32);
    $display("valid image test done");
    run(1'b0, 1'b0, 1'b0, 8'h5b);
    chk_fallback(1'b1, 1'b1);
    $display("bad signature test done");
    run(1'b0, 1'b0, 1'b1, 8'h5a);
    chk_fallback(1'b1, 1'b1);
    $display("refused address test done");
    report_and_stop;
  end
endmodule
bind udcl_loader udcl_loader_sva #(.DEFAULT_VID(DEFAULT_VID),
  .DEFAULT_PID(DEFAULT_PID)) udcl_loader_sva_inst (.core_clk(core_clk),
  .nrst(nrst), .cdc_mode(cdc_mode), .sda_in(sda_in), .scl_in(scl_in),
  .sda_oe(sda_oe), .scl_oe(scl_oe), .load_done(load_done),
  .image_valid(image_valid), .id_vendor(id_vendor),
  .id_product(id_product), .bm_attributes(bm_attributes),
  .b_max_power(b_max_power), .max_packet_size(max_packet_size),
  .num_configs(num_configs), .num_interfaces(num_interfaces),
  .num_endpoints(num_endpoints), .flow_control(flow_control),
  .pin_mode(pin_mode), .pin_int_mask(pin_int_mask),
  .pin_direction(pin_direction), .baud_rate(baud_rate),
  .data_bits(data_bits), .parity_en(parity_en), .stop_bits(stop_bits));
